// ===== include/fpsc_pkg.sv
/*
  fpsc_pkg: constants and types for the flash power state control block.
  Assumes a 25 MHz system clock and a chip mode code from the mode controller.
*/
package fpsc_pkg;
  // chip operating modes as delivered by the mode controller
  typedef enum logic [2:0] {
    FPSC_CHIP_ACTIVE,
    FPSC_CHIP_SUBACTIVE,
    FPSC_CHIP_SLEEP,
    FPSC_CHIP_SUBSLEEP,
    FPSC_CHIP_STANDBY,
    FPSC_CHIP_WATCH
  } fpsc_chip_mode_e;

  // flash operating states
  typedef enum logic [1:0] {
    FPSC_FLASH_NORMAL,
    FPSC_FLASH_POWERDOWN,
    FPSC_FLASH_STANDBY
  } fpsc_flash_state_e;

  localparam int CLK_HZ = 25000000;
  localparam int SETUP_MS = 10;
  localparam int SETUP_CYCLES = (SETUP_MS * (CLK_HZ / 1000));
  localparam int OSC_MS = 10;
  localparam int OSC_CYCLES = (OSC_MS * (CLK_HZ / 1000));
  localparam int MIN_WAIT_US = 20;
  localparam int MIN_WAIT_CYCLES = (MIN_WAIT_US * (CLK_HZ / 1000000));

  localparam int WAIT_W = 16;
  localparam int SEL_W = 3;
  localparam logic PDWN_DIS_RESET = 1'h0;

  // flash state outputs travel together
  typedef struct packed {
    logic supply_partial;
    logic circuits_halted;
    logic read_ok;
    logic write_ok;
    logic access_ok;
  } fpsc_flash_ctl_s;
endpackage

// ===== logic/fpsc_flash_power.sv
/*
  fpsc_flash_power: flash power state selection, return settling wait and
  programmer mode command lockout with automatic entry to memory read mode.
  Assumes synchronous inputs on i_clk, a chip mode code from the mode
  controller and a disable bit write strobe from the system control logic.
  Reset is synchronous and active high; it clears the disable bit and timers.
  Every status output is a flip-flop; only the command accept is combinational.
*/
`timescale 1ns/10ps
module fpsc_flash_power #(
  parameter int SETUP_CYCLES = fpsc_pkg::SETUP_CYCLES,
  parameter int OSC_CYCLES = fpsc_pkg::OSC_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // chip mode and disable bit control
  input wire fpsc_pkg::fpsc_chip_mode_e i_chip_mode,
  input wire logic i_pdwn_dis_we,
  input wire logic i_pdwn_dis_wdata,
  input wire logic [fpsc_pkg::SEL_W-1:0] i_standby_wait_select,
  // programmer mode side
  input wire logic i_prog_mode,
  input wire logic i_prog_cmd_valid,
  // flash state outputs
  output logic o_flash_powerdown_disable,
  output fpsc_pkg::fpsc_flash_state_e o_flash_state,
  output fpsc_pkg::fpsc_flash_ctl_s o_flash_ctl,
  output logic o_settling,
  // programmer outputs
  output logic o_prog_cmd_accept,
  output logic o_prog_cmd_wait,
  output logic o_mem_read_mode
);
  typedef enum logic [1:0] {
    FPSC_PM_IDLE,
    FPSC_PM_OSC,
    FPSC_PM_SETUP,
    FPSC_PM_READY
  } fpsc_pm_e;

  localparam int PM_W = $clog2(OSC_CYCLES + SETUP_CYCLES + 1);
  localparam logic [PM_W-1:0] OSC_LAST = PM_W'(OSC_CYCLES - 1);
  localparam logic [PM_W-1:0] SETUP_LAST = PM_W'(SETUP_CYCLES - 1);

  // step sizes kept at counter width
  localparam logic [PM_W-1:0] PM_CNT_ONE = PM_W'(1);
  localparam logic [fpsc_pkg::WAIT_W-1:0] WAIT_ONE = fpsc_pkg::WAIT_W'(1);

  // wait per select code; every code meets the minimum even on an external clock
  // the largest code still fits the wait counter
  function automatic logic [fpsc_pkg::WAIT_W-1:0] fpsc_wait_cycles(input logic [fpsc_pkg::SEL_W-1:0] sel);
    fpsc_wait_cycles = fpsc_pkg::WAIT_W'(fpsc_pkg::MIN_WAIT_CYCLES) << sel;
  endfunction

  // chip mode to flash state; the disable bit only matters in subactive
  function automatic fpsc_pkg::fpsc_flash_state_e fpsc_target(input fpsc_pkg::fpsc_chip_mode_e m, input logic dis);
    case (m)
      fpsc_pkg::FPSC_CHIP_ACTIVE: begin
        fpsc_target = fpsc_pkg::FPSC_FLASH_NORMAL;
      end
      fpsc_pkg::FPSC_CHIP_SLEEP: begin
        fpsc_target = fpsc_pkg::FPSC_FLASH_NORMAL;
      end
      fpsc_pkg::FPSC_CHIP_SUBACTIVE: begin
        if (dis) begin
          fpsc_target = fpsc_pkg::FPSC_FLASH_NORMAL;
        end else begin
          fpsc_target = fpsc_pkg::FPSC_FLASH_POWERDOWN;
        end
      end
      fpsc_pkg::FPSC_CHIP_SUBSLEEP,
      fpsc_pkg::FPSC_CHIP_STANDBY,
      fpsc_pkg::FPSC_CHIP_WATCH: begin
        fpsc_target = fpsc_pkg::FPSC_FLASH_STANDBY;
      end
      // unused codes park the flash in its safest state
      default: begin
        fpsc_target = fpsc_pkg::FPSC_FLASH_STANDBY;
      end
    endcase
  endfunction

  // one decode serves the registered outputs and their reset value
  function automatic fpsc_pkg::fpsc_flash_ctl_s fpsc_ctl_decode(input fpsc_pkg::fpsc_flash_state_e st,
                                                                input logic busy);
    fpsc_pkg::fpsc_flash_ctl_s c;
    c.supply_partial = (st == fpsc_pkg::FPSC_FLASH_POWERDOWN);
    c.circuits_halted = (st == fpsc_pkg::FPSC_FLASH_STANDBY);
    // power-down keeps reads; only normal takes writes
    c.read_ok = (st != fpsc_pkg::FPSC_FLASH_STANDBY) && !busy;
    c.write_ok = (st == fpsc_pkg::FPSC_FLASH_NORMAL) && !busy;
    // no access of any kind until the supply has settled
    c.access_ok = c.read_ok;
    fpsc_ctl_decode = c;
  endfunction

  // oscillator and setup intervals end alike
  function automatic logic fpsc_interval_end(input logic [PM_W-1:0] cnt, input logic [PM_W-1:0] last);
    fpsc_interval_end = (cnt == last);
  endfunction

  // flash state group
  logic pdwn_dis_r, pdwn_dis_nxt;
  fpsc_pkg::fpsc_flash_state_e state_r, state_nxt;
  logic [fpsc_pkg::WAIT_W-1:0] wait_r, wait_nxt;
  logic settling_r, settling_nxt;
  fpsc_pkg::fpsc_flash_ctl_s ctl_r, ctl_nxt;
  fpsc_pkg::fpsc_flash_state_e target;
  logic returning;

  // programmer mode group
  fpsc_pm_e pm_r, pm_nxt;
  logic [PM_W-1:0] pm_cnt_r, pm_cnt_nxt;
  logic read_mode_r, read_mode_nxt;

  // wait counter and its busy flag move together, so outputs never disagree
  always_comb begin
    target = fpsc_target(i_chip_mode, pdwn_dis_r);
    returning = (target == fpsc_pkg::FPSC_FLASH_NORMAL) && (state_r != fpsc_pkg::FPSC_FLASH_NORMAL);
    pdwn_dis_nxt = i_pdwn_dis_we ? i_pdwn_dis_wdata : pdwn_dis_r;
    state_nxt = target;
    wait_nxt = wait_r;
    if (returning) begin
      // supply was partial or circuits were halted; give them the programmed time
      wait_nxt = fpsc_wait_cycles(i_standby_wait_select);
    end else if (target != fpsc_pkg::FPSC_FLASH_NORMAL) begin
      wait_nxt = '0;
    end else if (wait_r != '0) begin
      wait_nxt = wait_r - WAIT_ONE;
    end
    settling_nxt = (wait_nxt != '0);
    ctl_nxt = fpsc_ctl_decode(state_nxt, settling_nxt);
  end

  // reset parks the flash in standby; the first mode then decides
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pdwn_dis_r <= fpsc_pkg::PDWN_DIS_RESET;
      state_r <= fpsc_pkg::FPSC_FLASH_STANDBY;
      wait_r <= '0;
      settling_r <= 1'h0;
      ctl_r <= fpsc_ctl_decode(fpsc_pkg::FPSC_FLASH_STANDBY, 1'h0);
    end else begin
      pdwn_dis_r <= pdwn_dis_nxt;
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      settling_r <= settling_nxt;
      ctl_r <= ctl_nxt;
    end
  end

  // programmer mode sequence; leaving the mode restarts it
  always_comb begin
    pm_nxt = pm_r;
    pm_cnt_nxt = pm_cnt_r;
    case (pm_r)
      FPSC_PM_IDLE: begin
        // counter parks at zero outside the timed intervals
        pm_cnt_nxt = '0;
        if (i_prog_mode) begin
          pm_nxt = FPSC_PM_OSC;
        end
      end
      FPSC_PM_OSC: begin
        pm_cnt_nxt = pm_cnt_r + PM_CNT_ONE;
        if (fpsc_interval_end(pm_cnt_r, OSC_LAST)) begin
          pm_nxt = FPSC_PM_SETUP;
          pm_cnt_nxt = '0;
        end
      end
      FPSC_PM_SETUP: begin
        pm_cnt_nxt = pm_cnt_r + PM_CNT_ONE;
        if (fpsc_interval_end(pm_cnt_r, SETUP_LAST)) begin
          pm_nxt = FPSC_PM_READY;
          pm_cnt_nxt = '0;
        end
      end
      FPSC_PM_READY: begin
        pm_cnt_nxt = '0;
      end
      default: begin
        pm_nxt = FPSC_PM_IDLE;
      end
    endcase
    // a dropped mode pin at any point throws away the elapsed time
    if (!i_prog_mode) begin
      pm_nxt = FPSC_PM_IDLE;
      pm_cnt_nxt = '0;
    end
    read_mode_nxt = (pm_nxt == FPSC_PM_READY);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pm_r <= FPSC_PM_IDLE;
      pm_cnt_r <= '0;
      read_mode_r <= 1'h0;
    end else begin
      pm_r <= pm_nxt;
      pm_cnt_r <= pm_cnt_nxt;
      read_mode_r <= read_mode_nxt;
    end
  end

  // status outputs straight from the registers above
  assign o_flash_powerdown_disable = pdwn_dis_r;
  assign o_flash_state = state_r;
  assign o_settling = settling_r;
  assign o_flash_ctl = ctl_r;
  assign o_mem_read_mode = read_mode_r;
  assign o_prog_cmd_wait = read_mode_r;
  // commands during oscillator or setup intervals are simply dropped
  assign o_prog_cmd_accept = i_prog_cmd_valid && read_mode_r;
endmodule

// ===== tb/fpsc_flash_power_checker.sv
/* fpsc_flash_power_checker: port assertions for the flash power block.
   assumes binding onto fpsc_flash_power with its interval parameters. */
`timescale 1ns/10ps
module fpsc_flash_power_checker #(
  parameter int SETUP_CYCLES = 6,
  parameter int OSC_CYCLES = 4
) (
  // clock and inputs
  input wire logic i_clk,
  input wire logic i_reset,
  input wire fpsc_pkg::fpsc_chip_mode_e i_chip_mode,
  input wire logic i_pdwn_dis_we,
  input wire logic i_pdwn_dis_wdata,
  input wire logic [fpsc_pkg::SEL_W-1:0] i_standby_wait_select,
  input wire logic i_prog_mode,
  input wire logic i_prog_cmd_valid,
  // watched outputs
  input wire logic o_flash_powerdown_disable,
  input wire fpsc_pkg::fpsc_flash_state_e o_flash_state,
  input wire fpsc_pkg::fpsc_flash_ctl_s o_flash_ctl,
  input wire logic o_settling,
  input wire logic o_prog_cmd_accept,
  input wire logic o_prog_cmd_wait,
  input wire logic o_mem_read_mode
);
  int settle_r, settle_nxt, prog_r, prog_nxt;
  always_comb begin
    settle_nxt = o_settling ? settle_r + 1 : 0;
    prog_nxt = i_prog_mode ? prog_r + 1 : 0;
  end
  always_ff @(posedge i_clk) begin
    settle_r <= i_reset ? 0 : settle_nxt;
    prog_r <= i_reset ? 0 : prog_nxt;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // two samples so the state register has seen the inputs
  sequence s_sub(logic d);
    i_chip_mode == fpsc_pkg::FPSC_CHIP_SUBACTIVE && o_flash_powerdown_disable == d;
  endsequence
  sequence s_in(logic c);
    c ##1 c;
  endsequence
  a_subact_pd: assert property (s_sub(1'b0) ##1 s_sub(1'b0) |-> o_flash_state == fpsc_pkg::FPSC_FLASH_POWERDOWN)
    else $error("subactive without disable not in power-down");
  a_subact_norm: assert property (s_sub(1'b1) ##1 s_sub(1'b1) |-> o_flash_state == fpsc_pkg::FPSC_FLASH_NORMAL)
    else $error("subactive with disable not normal");
  a_run_normal: assert property (s_in(i_chip_mode inside {fpsc_pkg::FPSC_CHIP_ACTIVE, fpsc_pkg::FPSC_CHIP_SLEEP})
    |-> o_flash_state == fpsc_pkg::FPSC_FLASH_NORMAL) else $error("active or sleep not normal");
  a_halt_standby: assert property (s_in(i_chip_mode > fpsc_pkg::FPSC_CHIP_SLEEP)
    |-> o_flash_state == fpsc_pkg::FPSC_FLASH_STANDBY) else $error("low power mode not standby");
  a_stby_halted: assert property (o_flash_state == fpsc_pkg::FPSC_FLASH_STANDBY |-> o_flash_ctl.circuits_halted
    && !o_flash_ctl.read_ok) else $error("standby circuits running");
  a_pd_reads: assert property (o_flash_state == fpsc_pkg::FPSC_FLASH_POWERDOWN && !o_settling
    |-> o_flash_ctl.supply_partial && o_flash_ctl.read_ok && !o_flash_ctl.write_ok) else $error("power-down misdecoded");
  a_settle_block: assert property (o_settling |-> !o_flash_ctl.access_ok) else $error("access while settling");
  a_settle_len: assert property ($fell(o_settling) && o_flash_state == fpsc_pkg::FPSC_FLASH_NORMAL
    |-> settle_r == (fpsc_pkg::MIN_WAIT_CYCLES << i_standby_wait_select)) else $error("settling wait length wrong");
  a_dis_write: assert property (i_pdwn_dis_we |=> o_flash_powerdown_disable == $past(i_pdwn_dis_wdata))
    else $error("disable bit write lost");
  a_lock_cmds: assert property (o_prog_cmd_accept |-> o_mem_read_mode && prog_r >= OSC_CYCLES + SETUP_CYCLES)
    else $error("command taken before setup ended");
  a_read_mode: assert property (prog_r == OSC_CYCLES + SETUP_CYCLES + 1 |-> o_mem_read_mode && o_prog_cmd_wait)
    else $error("memory read mode not entered");
  a_lock_early: assert property (prog_r <= OSC_CYCLES + SETUP_CYCLES |-> !o_mem_read_mode && !o_prog_cmd_accept)
    else $error("read mode or accept before setup ended");
endmodule
bind fpsc_flash_power fpsc_flash_power_checker #(.SETUP_CYCLES(SETUP_CYCLES), .OSC_CYCLES(OSC_CYCLES)) chk_inst (.*);

// ===== tb/fpsc_prog_model.sv
/* fpsc_prog_model: external programmer holding commands back after entry.
   assumes the bench raises i_go at a falling edge. */
`timescale 1ns/10ps
module fpsc_prog_model #(
  parameter int WAIT = 14
) (
  // control from bench
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_early,
  input wire logic i_accept,
  // programmer pins
  output logic o_prog_mode,
  output logic o_cmd_valid,
  output logic o_cmd_erase
);
  int cnt_r;
  logic erase_pend_r;
  always_ff @(posedge i_clk) cnt_r <= i_go ? cnt_r + 1 : 0;
  // first command through after entry is a whole-array erase, whatever the history
  always_ff @(posedge i_clk) erase_pend_r <= i_go ? (erase_pend_r && !i_accept) : 1'b1;
  assign o_cmd_erase = o_cmd_valid && erase_pend_r;
  assign o_prog_mode = i_go;
  // i_early breaks the setup wait so the lockout can be seen
  assign o_cmd_valid = i_go && (i_early || cnt_r >= WAIT);
endmodule

// ===== tb/tb_top.sv
/* tb_top: self-checking bench for fpsc_flash_power.
   assumes short programmer intervals of 4 and 6 cycles. */
`timescale 1ns/10ps
module tb_top;
  logic i_clk = 1'b0, i_reset = 1'b1, we = 1'b0, wd = 1'b0, go = 1'b0, early = 1'b0;
  logic [2:0] sel = 3'h0;
  fpsc_pkg::fpsc_chip_mode_e mode = fpsc_pkg::FPSC_CHIP_STANDBY;
  logic pm, cv, dis, sett, acc, cw, mrm, ers;
  fpsc_pkg::fpsc_flash_state_e st;
  fpsc_pkg::fpsc_flash_ctl_s ctl;
  int bad_count = 0, n_checks = 0;
  always #20 i_clk = ~i_clk;
  fpsc_flash_power #(.SETUP_CYCLES(6), .OSC_CYCLES(4)) fpsc_flash_power_inst (.i_clk(i_clk), .i_reset(i_reset),
    .i_chip_mode(mode), .i_pdwn_dis_we(we), .i_pdwn_dis_wdata(wd), .i_standby_wait_select(sel), .i_prog_mode(pm),
    .i_prog_cmd_valid(cv), .o_flash_powerdown_disable(dis), .o_flash_state(st), .o_flash_ctl(ctl), .o_settling(sett),
    .o_prog_cmd_accept(acc), .o_prog_cmd_wait(cw), .o_mem_read_mode(mrm));
  fpsc_prog_model #(.WAIT(14)) fpsc_prog_model_inst (.i_clk(i_clk), .i_go(go), .i_early(early), .i_accept(acc),
    .o_prog_mode(pm), .o_cmd_valid(cv), .o_cmd_erase(ers));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_state(input fpsc_pkg::fpsc_flash_state_e got, input int e);
    chk_bit(got === fpsc_pkg::fpsc_flash_state_e'(e[1:0]), 1'b1, "flash state");
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic t_modes();
    int e;
    for (int d = 0; d < 2; d++) begin
      wd = d[0];
      we = 1'b1;
      cyc(1);
      we = 1'b0;
      for (int m = 0; m < 6; m++) begin
        mode = fpsc_pkg::fpsc_chip_mode_e'(m[2:0]);
        cyc(3);
        e = (m > 2) ? 2 : (m == 1 && d == 0) ? 1 : 0;
        chk_state(st, e);
        chk_bit(ctl.circuits_halted, e == 2, "halt");
        chk_bit(ctl.supply_partial, e == 1, "partial supply");
        if (e != 0) begin
          chk_bit(ctl.read_ok, e == 1, "low power reads");
        end
      end
    end
  endtask
  task automatic t_settle();
    int n;
    n = 0;
    sel = 3'h1;
    mode = fpsc_pkg::FPSC_CHIP_WATCH;
    cyc(3);
    mode = fpsc_pkg::FPSC_CHIP_ACTIVE;
    cyc(1);
    while (sett === 1'b1 && n < 3000) begin
      chk_bit(ctl.access_ok, 1'b0, "access while settling");
      n++;
      cyc(1);
    end
    chk_bit(n == (fpsc_pkg::MIN_WAIT_CYCLES << 1), 1'b1, "settle length");
    chk_bit(ctl.write_ok, 1'b1, "write after settle");
  endtask
  task automatic t_prog();
    int n;
    n = 0;
    early = 1'b1;
    go = 1'b1;
    while (mrm !== 1'b1 && n < 40) begin
      chk_bit(acc, 1'b0, "early accept");
      n++;
      cyc(1);
    end
    chk_bit(n >= 10 && n < 40, 1'b1, "read mode timing");
    chk_bit(acc && cw, 1'b1, "command refused");
    chk_bit(ers, 1'b1, "first command not an erase");
    go = 1'b0;
    early = 1'b0;
    cyc(2);
    chk_bit(mrm, 1'b0, "read mode stuck");
  endtask
  task automatic t_reset();
    i_reset = 1'b1;
    cyc(2);
    chk_bit(dis, 1'b0, "disable after reset");
    chk_state(st, 2);
    i_reset = 1'b0;
    mode = fpsc_pkg::FPSC_CHIP_SUBACTIVE;
    cyc(2);
    chk_state(st, 1);
  endtask
  task automatic t_prog_wait();
    go = 1'b1;
    cyc(14);
    chk_bit(mrm, 1'b1, "read mode after setup");
    chk_bit(acc && ers, 1'b1, "erase refused after wait");
    go = 1'b0;
    cyc(2);
  endtask
  initial begin
    cyc(6);
    i_reset = 1'b0;
    cyc(1);
    chk_bit(dis, 1'b0, "disable reset");
    t_modes();
    t_settle();
    t_prog();
    t_reset();
    t_prog_wait();
    stop_test();
  end
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule
